// [flash_host_pkg.sv]
// flash_host_pkg: constants and carriers for the parallel flash host controller
// assumes a 25 MHz system clock and a 128K x 8 flash on the far side
package flash_host_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CLK_NS = 40;
    // command bytes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hC0;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [ADDR_W-1:0] ADDR_MAKER_ID = 17'h00000;
    localparam logic [ADDR_W-1:0] ADDR_PART_ID = 17'h00001;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 17'h1FFFF;
    // timing, figures in their own units
    localparam int T_WE_LOW_NS = 40;
    localparam int T_WE_HIGH_NS = 20;
    localparam int T_ACCESS_NS = 120;
    localparam int T_PROG_US = 10;
    localparam int T_ERASE_US = 9500;
    localparam int T_WREC_US = 6;
    localparam int CYC_WE_LOW = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_WE_HIGH = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_ACCESS = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_PROG = (T_PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_ERASE = (T_ERASE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CYC_WREC = (T_WREC_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 20;
    localparam int RETRY_W = 12;
    localparam logic [RETRY_W-1:0] PROG_RETRIES = 12'h019;
    localparam logic [RETRY_W-1:0] ERASE_RETRIES = 12'h3E8;

    typedef enum logic [2:0] {
        OP_READ = 3'b000,
        OP_IDENT = 3'b001,
        OP_PROGRAM = 3'b010,
        OP_ERASE = 3'b011,
        OP_ABORT = 3'b100
    } op_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic vpp_high;
        logic id_voltage;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic data_oe_n;
    } pins_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic fail;
    } resp_t;
endpackage

// [flash_bus_cycle.sv]
// flash_bus_cycle: one timed write or read cycle on the flash pins
// assumes the caller holds i_start for one cycle while o_idle is high
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_data,
    input wire logic [DATA_W-1:0] i_din,
    output logic o_idle,
    output logic o_done,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_dout,
    output logic o_data_oe_n,
    output logic [DATA_W-1:0] o_rdata
);
    typedef enum logic [1:0] {
        BC_IDLE = 2'b00,
        BC_LOW = 2'b01,
        BC_HIGH = 2'b10
    } bc_state_t;

    localparam logic [3:0] LOW_CNT = 4'(CYC_WE_LOW);
    localparam logic [3:0] HIGH_CNT = 4'(CYC_WE_HIGH);
    localparam logic [3:0] ACC_CNT = 4'(CYC_ACCESS);

    bc_state_t state_reg;
    logic [3:0] cnt_reg;
    logic write_reg;

    assign o_idle = (state_reg == BC_IDLE);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= BC_IDLE;
            cnt_reg <= 4'h0;
            write_reg <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state_reg)
                BC_IDLE: begin
                    if (i_start) begin
                        write_reg <= i_write;
                        cnt_reg <= i_write ? LOW_CNT : ACC_CNT;
                        state_reg <= BC_LOW;
                    end
                end
                BC_LOW: begin
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        cnt_reg <= HIGH_CNT;
                        state_reg <= BC_HIGH;
                    end
                end
                BC_HIGH: begin
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        o_done <= 1'b1;
                        state_reg <= BC_IDLE;
                    end
                end
                default: state_reg <= BC_IDLE;
            endcase
        end
    end

    // address set on the same edge the strobe falls, so it is latched on the falling edge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_addr <= '0;
            o_dout <= 8'h00;
            o_rdata <= 8'h00;
        end else if (o_idle && i_start) begin
            o_addr <= i_addr;
            o_dout <= i_data;
        end else if (state_reg == BC_LOW && !write_reg && cnt_reg == 4'h1) begin
            o_rdata <= i_din;
        end
    end

    // strobes: chip select low through the cycle, data held past the rising edge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_data_oe_n <= 1'b1;
        end else begin
            o_ce_n <= !((o_idle && i_start) || (state_reg == BC_LOW) ||
                        (state_reg == BC_HIGH && cnt_reg > 4'h1));
            o_we_n <= !((o_idle && i_start && i_write) ||
                        (state_reg == BC_LOW && write_reg && cnt_reg > 4'h1));
            o_oe_n <= !((o_idle && i_start && !i_write) ||
                        (state_reg == BC_LOW && !write_reg && cnt_reg > 4'h1));
            o_data_oe_n <= !((o_idle && i_start && i_write) ||
                             (state_reg != BC_IDLE && write_reg && !(state_reg == BC_HIGH && cnt_reg == 4'h1)));
        end
    end

    AST_WRITE_NO_READ_OVERLAP: assert property (@(posedge i_clk) disable iff (i_srst)
        !(o_we_n == 1'b0 && o_oe_n == 1'b0))
        else $error("write and output strobes both low");
    AST_DATA_HELD_AT_RISE: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(o_we_n) |-> !o_data_oe_n && $stable(o_dout))
        else $error("data not driven at strobe rise");
endmodule
`default_nettype wire

// [flash_host_ctrl.sv]
// flash_host_ctrl: host controller running command sequences on a parallel flash
// assumes flash pins are reached through an external driver; data pins are split in/out/enable
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl
    import flash_host_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_REQ_VALID,
    input wire req_t I_REQ,
    input wire logic I_ID_BY_VOLTAGE,
    output logic O_REQ_READY,
    output logic O_RESP_VALID,
    output resp_t O_RESP,
    output pins_t O_PINS,
    input wire logic [DATA_W-1:0] I_DATA_LINES
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_CMD1 = 4'b0001,
        S_CMD2 = 4'b0010,
        S_PULSE = 4'b0011,
        S_VERIFY_CMD = 4'b0100,
        S_RECOVER = 4'b0101,
        S_VERIFY_RD = 4'b0110,
        S_EXIT = 4'b0111,
        S_READ = 4'b1000,
        S_DONE = 4'b1001
    } state_t;

    state_t state_reg;
    req_t req_reg;
    logic [CNT_W-1:0] wait_reg;
    logic [RETRY_W-1:0] tries_reg;
    logic [ADDR_W-1:0] cur_addr_reg;
    logic fail_reg;
    logic prezero_reg;
    logic bc_start, bc_write, bc_idle, bc_done;
    logic [ADDR_W-1:0] bc_addr;
    logic [DATA_W-1:0] bc_data, bc_rdata;
    logic pin_ce_n, pin_oe_n, pin_we_n, pin_data_oe_n, vpp_reg, idv_reg;
    logic [ADDR_W-1:0] pin_addr;
    logic [DATA_W-1:0] pin_dout;

    // command byte written in the first write of each sequence
    function automatic logic [7:0] first_cmd(input op_t op);
        unique case (op)
            OP_PROGRAM: first_cmd = CMD_PROGRAM;
            OP_ERASE: first_cmd = CMD_ERASE;
            OP_ABORT: first_cmd = CMD_RESET;
            OP_IDENT: first_cmd = CMD_IDENT;
            default: first_cmd = CMD_READ;
        endcase
    endfunction

    assign O_REQ_READY = (state_reg == S_IDLE);

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_reg <= S_EXIT;
            req_reg <= '0;
            wait_reg <= '0;
            tries_reg <= '0;
            cur_addr_reg <= '0;
            fail_reg <= 1'b0;
            prezero_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    if (I_REQ_VALID) begin
                        req_reg <= I_REQ;
                        fail_reg <= 1'b0;
                        tries_reg <= '0;
                        cur_addr_reg <= '0;
                        prezero_reg <= (I_REQ.op == OP_ERASE);
                        if (I_REQ.op == OP_READ || (I_REQ.op == OP_IDENT && I_ID_BY_VOLTAGE))
                            state_reg <= S_READ;
                        else
                            state_reg <= S_CMD1;
                    end
                end
                S_CMD1: if (bc_done) begin
                    state_reg <= (req_reg.op == OP_IDENT) ? S_READ : S_CMD2;
                end
                S_CMD2: if (bc_done) begin
                    if (req_reg.op == OP_ABORT) begin
                        state_reg <= S_DONE;
                    end else begin
                        wait_reg <= (req_reg.op == OP_ERASE && !prezero_reg) ?
                            CNT_W'(CYC_ERASE) : CNT_W'(CYC_PROG);
                        state_reg <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    if (wait_reg > CNT_W'(1)) wait_reg <= wait_reg - CNT_W'(1);
                    else state_reg <= S_VERIFY_CMD;
                end
                S_VERIFY_CMD: if (bc_done) begin
                    wait_reg <= CNT_W'(CYC_WREC);
                    state_reg <= S_RECOVER;
                end
                S_RECOVER: begin
                    if (wait_reg > CNT_W'(1)) wait_reg <= wait_reg - CNT_W'(1);
                    else state_reg <= S_VERIFY_RD;
                end
                S_VERIFY_RD: if (bc_done) begin
                    if (req_reg.op == OP_ERASE && !prezero_reg) begin
                        if (bc_rdata == ERASED_BYTE) begin
                            if (cur_addr_reg == ADDR_LAST) state_reg <= S_EXIT;
                            else begin
                                cur_addr_reg <= cur_addr_reg + 17'h00001;
                                state_reg <= S_VERIFY_CMD;
                            end
                        end else if (tries_reg == ERASE_RETRIES) begin
                            fail_reg <= 1'b1;
                            state_reg <= S_EXIT;
                        end else begin
                            tries_reg <= tries_reg + 12'h001;
                            state_reg <= S_CMD1;
                        end
                    end else begin
                        if (bc_rdata == (prezero_reg ? CMD_READ : req_reg.data)) begin
                            tries_reg <= '0;
                            if (!prezero_reg) state_reg <= S_EXIT;
                            else if (cur_addr_reg == ADDR_LAST) begin
                                prezero_reg <= 1'b0;
                                cur_addr_reg <= '0;
                                state_reg <= S_CMD1;
                            end else begin
                                cur_addr_reg <= cur_addr_reg + 17'h00001;
                                state_reg <= S_CMD1;
                            end
                        end else if (tries_reg == PROG_RETRIES) begin
                            fail_reg <= 1'b1;
                            state_reg <= S_EXIT;
                        end else begin
                            tries_reg <= tries_reg + 12'h001;
                            state_reg <= S_CMD1;
                        end
                    end
                end
                S_EXIT: if (bc_done) state_reg <= S_DONE;
                S_READ: if (bc_done) state_reg <= S_DONE;
                S_DONE: state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    always_comb begin
        bc_start = 1'b0;
        bc_write = 1'b1;
        bc_addr = '0;
        bc_data = CMD_READ;
        if (bc_idle && !bc_done) begin
            unique case (state_reg)
                S_CMD1: begin
                    bc_start = 1'b1;
                    bc_data = prezero_reg ? CMD_PROGRAM : first_cmd(req_reg.op);
                end
                S_CMD2: begin
                    bc_start = 1'b1;
                    if (req_reg.op == OP_ERASE && !prezero_reg) begin
                        bc_data = CMD_ERASE;
                    end else if (req_reg.op == OP_ABORT) begin
                        bc_data = CMD_RESET;
                    end else begin
                        bc_addr = prezero_reg ? cur_addr_reg : req_reg.addr;
                        bc_data = prezero_reg ? CMD_READ : req_reg.data;
                    end
                end
                S_VERIFY_CMD: begin
                    bc_start = 1'b1;
                    if (req_reg.op == OP_ERASE && !prezero_reg) begin
                        bc_addr = cur_addr_reg;
                        bc_data = CMD_ERASE_VERIFY;
                    end else begin
                        bc_data = CMD_PROGRAM_VERIFY;
                    end
                end
                S_VERIFY_RD: begin
                    bc_start = 1'b1;
                    bc_write = 1'b0;
                end
                S_EXIT: begin
                    bc_start = 1'b1;
                    bc_data = CMD_READ;
                end
                S_READ: begin
                    bc_start = 1'b1;
                    bc_write = 1'b0;
                    bc_addr = req_reg.addr;
                    if (req_reg.op == OP_IDENT && I_ID_BY_VOLTAGE)
                        bc_addr = {{(ADDR_W-1){1'b0}}, req_reg.addr[0]};
                end
                default: bc_start = 1'b0;
            endcase
        end
    end

    flash_bus_cycle u_cycle (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_start(bc_start),
        .i_write(bc_write),
        .i_addr(bc_addr),
        .i_data(bc_data),
        .i_din(I_DATA_LINES),
        .o_idle(bc_idle),
        .o_done(bc_done),
        .o_ce_n(pin_ce_n),
        .o_oe_n(pin_oe_n),
        .o_we_n(pin_we_n),
        .o_addr(pin_addr),
        .o_dout(pin_dout),
        .o_data_oe_n(pin_data_oe_n),
        .o_rdata(bc_rdata)
    );

    // pin bundle gathered in one place so the struct has a single driver
    assign O_PINS = '{ce_n: pin_ce_n, oe_n: pin_oe_n, we_n: pin_we_n, vpp_high: vpp_reg,
        id_voltage: idv_reg, addr: pin_addr, dout: pin_dout, data_oe_n: pin_data_oe_n};

    // program supply raised while a command sequence or an identification read runs
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            vpp_reg <= 1'b0;
            idv_reg <= 1'b0;
        end else begin
            vpp_reg <= !(state_reg == S_IDLE || state_reg == S_DONE ||
                (state_reg == S_READ && req_reg.op != OP_IDENT));
            idv_reg <= (state_reg == S_READ && req_reg.op == OP_IDENT && I_ID_BY_VOLTAGE);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_RESP_VALID <= 1'b0;
            O_RESP <= '0;
        end else begin
            O_RESP_VALID <= (state_reg == S_DONE);
            if (state_reg == S_DONE) begin
                O_RESP.data <= bc_rdata;
                O_RESP.fail <= fail_reg;
            end
        end
    end

    AST_WRITE_NEEDS_SUPPLY: assert property (@(posedge I_CLK) disable iff (I_SRST)
        !O_PINS.we_n |-> O_PINS.vpp_high)
        else $error("command write without program supply");
    AST_ERASE_TWICE: assert property (@(posedge I_CLK) disable iff (I_SRST)
        (state_reg == S_CMD2 && bc_start && req_reg.op == OP_ERASE && !prezero_reg)
        |-> bc_data == CMD_ERASE)
        else $error("second erase byte wrong");
    AST_PULSE_THEN_VERIFY: assert property (@(posedge I_CLK) disable iff (I_SRST)
        (state_reg == S_PULSE && wait_reg == CNT_W'(1)) |=> state_reg == S_VERIFY_CMD)
        else $error("verify not issued after pulse wait");
    AST_ID_VOLT_ADDR: assert property (@(posedge I_CLK) disable iff (I_SRST)
        O_PINS.id_voltage && !O_PINS.oe_n |-> O_PINS.addr[ADDR_W-1:1] == '0 && O_PINS.we_n)
        else $error("upper address set during voltage identification");
    AST_STANDBY_IDLE: assert property (@(posedge I_CLK) disable iff (I_SRST)
        (state_reg == S_IDLE && bc_idle) [*2] |-> O_PINS.ce_n && O_PINS.data_oe_n)
        else $error("chip selected while idle");
    AST_RESP_AFTER_DONE: assert property (@(posedge I_CLK) disable iff (I_SRST)
        state_reg == S_DONE |=> O_RESP_VALID ##1 !O_RESP_VALID)
        else $error("response not one cycle");
endmodule
`default_nettype wire

// [flash_partner.sv]
// flash_partner: behavioural flash array and command register, seen through the host pins
// assumes pins are sampled on the host clock; o_data is the resolved level of the data lines
`timescale 1ns/100ps
`default_nettype none
module flash_partner
    import flash_host_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'hC3 // arbitrary value
)(
    input wire logic i_clk,
    input wire pins_t i_pins,
    output logic [DATA_W-1:0] o_data,
    output logic [7:0] o_viol
);
    localparam int M_READ = 0;
    localparam int M_IDENT = 1;
    localparam int M_ERASE_ARM = 2;
    localparam int M_PROG = 3;
    localparam int M_PVERIFY = 4;
    localparam int M_ABORT_ARM = 5;
    localparam int M_EVERIFY = 6;
    logic [7:0] mem [int];
    logic [ADDR_W-1:0] lat_addr_reg = '0;
    logic [ADDR_W-1:0] fall_addr_reg = '0;
    logic prev_we_reg = 1'b1;
    logic [7:0] last_reg = 8'h00;
    logic [7:0] viol_reg = 8'h00;
    logic [7:0] fdata;
    int mode_reg = M_READ;

    function automatic logic [7:0] rd(input logic [ADDR_W-1:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : ERASED_BYTE;
    endfunction

    always_comb begin
        if (i_pins.id_voltage) begin
            fdata = i_pins.addr[0] ? PART_CODE : MAKER_CODE;
        end else if (i_pins.vpp_high && mode_reg == M_IDENT) begin
            fdata = i_pins.addr[0] ? PART_CODE : MAKER_CODE;
        end else if (i_pins.vpp_high && (mode_reg == M_PVERIFY || mode_reg == M_EVERIFY)) begin
            fdata = rd(lat_addr_reg);
        end else begin
            fdata = rd(i_pins.addr);
        end
    end

    // released lines float with no pull, so show a toggling pattern instead of a stale byte
    always_comb begin
        if (!i_pins.data_oe_n) begin
            o_data = i_pins.dout;
        end else if (!i_pins.ce_n && !i_pins.oe_n && i_pins.we_n) begin
            o_data = fdata;
        end else begin
            o_data = ~last_reg;
        end
    end
    assign o_viol = viol_reg;

    always @(posedge i_clk) begin
        last_reg <= o_data;
        prev_we_reg <= i_pins.we_n;
        // every write latches an address, but verify keeps the one committed by
        // the program write or the erase-verify write, not the verify command's
        if (!i_pins.ce_n && prev_we_reg && !i_pins.we_n) begin
            fall_addr_reg <= i_pins.addr;
        end
        if (i_pins.id_voltage && i_pins.addr[ADDR_W-1:1] != '0) begin
            viol_reg <= viol_reg + 8'h01;
        end
        if (!i_pins.ce_n && !i_pins.oe_n && i_pins.vpp_high && !i_pins.id_voltage
            && (mode_reg == M_ERASE_ARM || mode_reg == M_PROG || mode_reg == M_ABORT_ARM)) begin
            viol_reg <= viol_reg + 8'h01;
        end
        if (!i_pins.ce_n && !prev_we_reg && i_pins.we_n && i_pins.vpp_high) begin
            if (mode_reg == M_PROG) begin
                // program pulse starts at this strobe and the byte is committed at once; bits only go from 1 to 0
                mem[int'(fall_addr_reg)] = rd(fall_addr_reg) & o_data;
                lat_addr_reg <= fall_addr_reg;
                mode_reg <= M_READ;
            end else if (mode_reg == M_ERASE_ARM && o_data == CMD_ERASE) begin
                mem.delete();
                mode_reg <= M_READ;
            end else if (mode_reg == M_ABORT_ARM && o_data == CMD_RESET) begin
                mode_reg <= M_READ;
            end else begin
                case (o_data)
                    CMD_IDENT: mode_reg <= M_IDENT;
                    CMD_ERASE: mode_reg <= M_ERASE_ARM;
                    CMD_ERASE_VERIFY: begin
                        mode_reg <= M_EVERIFY;
                        lat_addr_reg <= fall_addr_reg;
                    end
                    CMD_PROGRAM: mode_reg <= M_PROG;
                    CMD_PROGRAM_VERIFY: mode_reg <= M_PVERIFY;
                    CMD_RESET: mode_reg <= M_ABORT_ARM;
                    default: mode_reg <= M_READ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [parallel_flash_command_unit_test.sv]
// parallel_flash_command_unit_test: drives host requests and checks answers against a bench model
// assumes flash_partner stands on the pins; chip erase is left out, its prezero alone runs millions of cycles
`timescale 1ns/100ps
`default_nettype none
module parallel_flash_command_unit_test;
    import flash_host_pkg::*;
    localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
    localparam logic [7:0] PART = 8'hC3; // arbitrary value
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    logic id_volt = 1'b0;
    req_t req = '0;
    logic req_ready;
    logic resp_valid;
    resp_t resp;
    resp_t got;
    pins_t pins;
    logic [DATA_W-1:0] data_lines;
    logic [7:0] viol;
    logic [7:0] bm [int];
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int a5;

    initial forever #20 clk = ~clk;

    flash_host_ctrl dut_u (.I_CLK(clk), .I_SRST(srst), .I_REQ_VALID(req_valid), .I_REQ(req),
        .I_ID_BY_VOLTAGE(id_volt), .O_REQ_READY(req_ready), .O_RESP_VALID(resp_valid),
        .O_RESP(resp), .O_PINS(pins), .I_DATA_LINES(data_lines));
    flash_partner #(.MAKER_CODE(MAKER), .PART_CODE(PART)) part_u (.i_clk(clk), .i_pins(pins),
        .o_data(data_lines), .o_viol(viol));

    task automatic results;
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_data(input string name, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_flag(input string name, input logic exp, input logic seen);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %b seen %b", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] bread(input int a);
        return bm.exists(a) ? bm[a] : ERASED_BYTE;
    endfunction

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            results();
        end
    end

    task automatic wait_resp;
        int n;
        n = 0;
        while (resp_valid !== 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_flag("resp_valid", 1'b1, resp_valid);
        got = resp;
    endtask

    task automatic do_reset;
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        wait_resp();
    endtask

    task automatic do_req(input op_t op, input int a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        req = '{op: op, addr: a[ADDR_W-1:0], data: d};
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        wait_resp();
    endtask

    task automatic rd_chk(input int a);
        do_req(OP_READ, a, 8'h00);
        chk_data("read data", bread(a), got.data);
    endtask

    // a byte fails when it asks for a 1 where the array already holds a 0
    task automatic prog(input int a, input logic [7:0] d);
        logic expf;
        expf = ((bread(a) & d) !== d);
        bm[a] = bread(a) & d;
        do_req(OP_PROGRAM, a, d);
        chk_flag("program fail", expf, got.fail);
        rd_chk(a);
    endtask

    initial begin
        void'($urandom(93));
        do_reset();
        for (int i = 0; i < 4; i++) begin
            rd_chk($urandom & 32'h0001FFFF);
        end
        for (int v = 0; v < 2; v++) begin
            for (int k = 0; k < 2; k++) begin
                id_volt = v[0];
                do_req(OP_IDENT, k, 8'h00);
                chk_data("ident code", k ? PART : MAKER, got.data);
            end
        end
        id_volt = 1'b0;
        prog(0, $urandom & 32'hFF);
        prog(int'(ADDR_LAST), $urandom & 32'hFF);
        for (int i = 0; i < 3; i++) begin
            prog($urandom & 32'h0001FFFF, $urandom & 32'hFF);
        end
        a5 = ($urandom & 32'h0000FFFF) | 32'h00010000;
        prog(a5, 8'h0F);
        prog(a5, 8'h05);
        prog(a5, 8'hF0);
        do_req(OP_ABORT, 0, 8'h00);
        chk_flag("abort fail", 1'b0, got.fail);
        rd_chk(a5);
        do_reset();
        rd_chk(a5);
        chk_data("pin violations", 8'h00, viol);
        results();
    end
endmodule
`default_nettype wire
